//--- verilog/eafsl_ctrl.sv
// Extra-area flag launch controller: takes a command from software over
// APB and drives the device flash sequencer registers over an APB master.
// Assumes the device answers every master access with pready eventually.
`timescale 1ns/100ps

module eafsl_ctrl (
   input  wire logic        clock,
   input  wire logic        rst_n,
   // Software APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Device APB master
   output logic             mPsel,
   output logic             mPenable,
   output logic             mPwrite,
   output logic [15:0]      mPaddr,
   output logic [31:0]      mPwdata,
   input  wire logic [31:0] mPrdata,
   input  wire logic        mPready
);

   // ----------------------------------------------------------------
   // Sequencer states, Gray coded along the boot swap launch path
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE   = 4'h0,
      ST_CHECK  = 4'h1,
      ST_RDSWAP = 4'h3,
      ST_RDSEC  = 4'h2,
      ST_WRSWAP = 4'h6,
      ST_SELECT = 4'h7,
      ST_WRLOW  = 4'h5,
      ST_WRHIGH = 4'h4,
      ST_START  = 4'hc,
      ST_POLL   = 4'hd
   } eafsl_state_t;

   eafsl_state_t        state_ff;
   eafsl_state_t        nxt_state;
   logic [1:0]          cmd_ff;
   logic [15:0]         argA_ff;
   logic [15:0]         argB_ff;
   logic [15:0]         secFlag_ff;
   logic [15:0]         swapSet_ff;
   logic                busy_ff;
   logic                done_ff;
   logic                refused_ff;
   logic                swapSet_ok_ff;
   logic                mPsel_ff;
   logic                mPenable_ff;
   eafsl_pkg::eafsl_xfer_t xfer_ff;
   eafsl_pkg::eafsl_xfer_t stepXfer;
   logic [31:0]         prdata_ff;
   logic                swWrite;
   logic                swRead;
   logic                mapped;
   logic                launchCmd;
   logic                xferDone;
   logic                cluster1;
   logic [15:0]         lowMask;

   // ----------------------------------------------------------------
   // Software register access
   // ----------------------------------------------------------------
   // Zero-wait slave keeps the software side simple to model
   // Misaligned and unmapped offsets both answer with an error
   assign pready  = 1'b1;
   assign swWrite = psel && penable && pwrite;
   assign swRead  = psel && !penable && !pwrite;
   assign mapped  = (paddr == eafsl_pkg::SW_CMD_OFS)
                 || (paddr == eafsl_pkg::SW_ARGA_OFS)
                 || (paddr == eafsl_pkg::SW_ARGB_OFS)
                 || (paddr == eafsl_pkg::SW_STATUS_OFS)
                 || (paddr == eafsl_pkg::SW_SECRD_OFS);
   assign pslverr = psel && penable && !mapped;
   assign prdata  = prdata_ff;

   // A command write while busy is dropped; status shows no change
   // Command value zero is no command and is dropped too
   assign launchCmd = swWrite && !busy_ff && (paddr == eafsl_pkg::SW_CMD_OFS)
                   && (pwdata[1:0] != eafsl_pkg::CMD_NONE);

   // Read data registered in the setup cycle, valid in the access phase
   // Unmapped reads return zero alongside the error
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         prdata_ff <= 32'h0000_0000;
      end else if (swRead) begin
         case (paddr)
            eafsl_pkg::SW_CMD_OFS:    prdata_ff <= {30'h0000_0000, cmd_ff};
            eafsl_pkg::SW_ARGA_OFS:   prdata_ff <= {16'h0000, argA_ff};
            eafsl_pkg::SW_ARGB_OFS:   prdata_ff <= {16'h0000, argB_ff};
            eafsl_pkg::SW_STATUS_OFS: prdata_ff <= {28'h000_0000, swapSet_ok_ff,
                                                    refused_ff, done_ff, busy_ff};
            eafsl_pkg::SW_SECRD_OFS:  prdata_ff <= {16'h0000, secFlag_ff};
            default:                  prdata_ff <= 32'h0000_0000;
         endcase
      end
   end

   // Argument registers, frozen while a launch runs
   // Only the low half is kept; upper bits never matter
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         argA_ff <= 16'h0000;
         argB_ff <= 16'h0000;
      end else if (swWrite && !busy_ff) begin
         if (paddr == eafsl_pkg::SW_ARGA_OFS) begin
            argA_ff <= pwdata[15:0];
         end
         if (paddr == eafsl_pkg::SW_ARGB_OFS) begin
            argB_ff <= pwdata[15:0];
         end
      end
   end

   // Command latch
   // Feeds the step decode and the command readback
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cmd_ff <= eafsl_pkg::CMD_NONE;
      end else if (launchCmd) begin
         cmd_ff <= pwdata[1:0];
      end
   end

   // ----------------------------------------------------------------
   // Derived write data
   // ----------------------------------------------------------------
   // Code 0x00 is cluster 1, every other code falls back to cluster 0
   assign cluster1 = (argA_ff[7:0] == eafsl_pkg::CLUSTER1_CODE);
   assign lowMask  = cluster1 ? eafsl_pkg::MASK_BOOT_CLUS1
                              : eafsl_pkg::MASK_ALL_ONES;

   // Transfer for the current step
   // Reads drive zero write data to keep the bus quiet
   always_comb begin
      stepXfer = '{addr: 16'h0000, write: 1'b0, wdata: 32'h0000_0000};
      case (state_ff)
         ST_CHECK:  stepXfer.addr = eafsl_pkg::DEV_SEQ_STAT_ADDR;
         ST_RDSWAP: stepXfer.addr = eafsl_pkg::DEV_SWAP_SET_ADDR;
         ST_RDSEC:  stepXfer.addr = eafsl_pkg::DEV_SEC_FLAG_ADDR;
         // Other swap bits go back exactly as read
         ST_WRSWAP: begin
            stepXfer.addr  = eafsl_pkg::DEV_SWAP_SET_ADDR;
            stepXfer.write = 1'b1;
            stepXfer.wdata = {16'h0000, swapSet_ff};
            stepXfer.wdata[eafsl_pkg::TMP_SWAP_MODE_BIT] = 1'b1;
            // Flag 0 means cluster 1, select 1 means cluster 1
            stepXfer.wdata[eafsl_pkg::TMP_BOOT_SEL_BIT] =
               ~secFlag_ff[eafsl_pkg::BOOT_FLAG_BIT];
         end
         ST_SELECT: begin
            stepXfer.addr  = eafsl_pkg::DEV_AREA_SEL_ADDR;
            stepXfer.write = 1'b1;
            stepXfer.wdata = {24'h00_0000, eafsl_pkg::AREA_SEL_EXTRA};
         end
         ST_WRLOW: begin
            stepXfer.addr  = eafsl_pkg::DEV_WDATA_LO_ADDR;
            stepXfer.write = 1'b1;
            case (cmd_ff)
               eafsl_pkg::CMD_BOOT_PROT: begin
                  stepXfer.wdata = {16'h0000, secFlag_ff};
                  stepXfer.wdata[eafsl_pkg::BOOT_PROT_BIT] = 1'b0;
               end
               eafsl_pkg::CMD_BOOT_SWAP: stepXfer.wdata = {16'h0000, lowMask};
               default: stepXfer.wdata =
                  {22'h00_0000, argA_ff[eafsl_pkg::BLOCK_NUM_W-1:0]};
            endcase
         end
         ST_WRHIGH: begin
            stepXfer.addr  = eafsl_pkg::DEV_WDATA_HI_ADDR;
            stepXfer.write = 1'b1;
            if (cmd_ff == eafsl_pkg::CMD_SHIELD) begin
               stepXfer.wdata =
                  {22'h00_0000, argB_ff[eafsl_pkg::BLOCK_NUM_W-1:0]};
            end else begin
               stepXfer.wdata = {16'h0000, eafsl_pkg::MASK_ALL_ONES};
            end
         end
         ST_START: begin
            stepXfer.addr  = eafsl_pkg::DEV_SEQ_START_ADDR;
            stepXfer.write = 1'b1;
            stepXfer.wdata = (cmd_ff == eafsl_pkg::CMD_SHIELD)
                           ? {24'h00_0000, eafsl_pkg::START_SHIELD}
                           : {24'h00_0000, eafsl_pkg::START_SEC_FLAG};
         end
         ST_POLL:   stepXfer.addr = eafsl_pkg::DEV_SEQ_STAT_ADDR;
         default:   stepXfer = '{addr: 16'h0000, write: 1'b0, wdata: 32'h0000_0000};
      endcase
   end

   // ----------------------------------------------------------------
   // Device APB master
   // ----------------------------------------------------------------
   // One idle cycle between transfers; costs speed, keeps setup clean
   // No timeout: a device that never answers stalls the launch
   assign xferDone = mPsel_ff && mPenable_ff && mPready;

   // Setup loads the step; access waits on the device ready
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mPsel_ff    <= 1'b0;
         mPenable_ff <= 1'b0;
         xfer_ff     <= '{addr: 16'h0000, write: 1'b0, wdata: 32'h0000_0000};
      end else if (xferDone) begin
         mPsel_ff    <= 1'b0;
         mPenable_ff <= 1'b0;
      end else if (mPsel_ff) begin
         mPenable_ff <= 1'b1;
      end else if (state_ff != ST_IDLE) begin
         mPsel_ff <= 1'b1;
         xfer_ff  <= stepXfer;
      end
   end

   assign mPsel    = mPsel_ff;
   assign mPenable = mPenable_ff;
   assign mPwrite  = xfer_ff.write;
   assign mPaddr   = xfer_ff.addr;
   assign mPwdata  = xfer_ff.wdata;

   // Captured device registers
   // Only reads whose values feed later writes are kept
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         secFlag_ff <= 16'h0000;
         swapSet_ff <= 16'h0000;
      end else if (xferDone) begin
         if (state_ff == ST_RDSEC) begin
            secFlag_ff <= mPrdata[15:0];
         end
         if (state_ff == ST_RDSWAP) begin
            swapSet_ff <= mPrdata[15:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Launch sequencer
   // ----------------------------------------------------------------
   // Refused launches end after the status read, writing nothing
   // Shield window needs no flag read and goes straight to select
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: if (launchCmd) nxt_state = ST_CHECK;
         ST_CHECK: if (xferDone) begin
            if (!mPrdata[eafsl_pkg::DST_CODE_MODE_BIT]
                || mPrdata[eafsl_pkg::DST_FLASH_BUSY_BIT]
                || mPrdata[eafsl_pkg::DST_EXTRA_BUSY_BIT]) begin
               nxt_state = ST_IDLE;
            end else if (cmd_ff == eafsl_pkg::CMD_SHIELD) begin
               nxt_state = ST_SELECT;
            end else if (cmd_ff == eafsl_pkg::CMD_BOOT_SWAP) begin
               nxt_state = ST_RDSWAP;
            end else begin
               nxt_state = ST_RDSEC;
            end
         end
         ST_RDSWAP: if (xferDone) nxt_state = ST_RDSEC;
         ST_RDSEC: if (xferDone) begin
            // Swap bit only written while temporary mode still clear
            if (cmd_ff == eafsl_pkg::CMD_BOOT_SWAP
                && !swapSet_ff[eafsl_pkg::TMP_SWAP_MODE_BIT]) begin
               nxt_state = ST_WRSWAP;
            end else begin
               nxt_state = ST_SELECT;
            end
         end
         ST_WRSWAP: if (xferDone) nxt_state = ST_SELECT;
         ST_SELECT: if (xferDone) nxt_state = ST_WRLOW;
         ST_WRLOW:  if (xferDone) nxt_state = ST_WRHIGH;
         ST_WRHIGH: if (xferDone) nxt_state = ST_START;
         ST_START:  if (xferDone) nxt_state = ST_POLL;
         // Completion check comes before any other sequencer access
         ST_POLL: if (xferDone && !mPrdata[eafsl_pkg::DST_EXTRA_BUSY_BIT]) begin
            nxt_state = ST_IDLE;
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   // State register, cleared straight to idle
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ----------------------------------------------------------------
   // Status flags
   // ----------------------------------------------------------------
   // New command clears old results; they only set while busy, so no clash
   // Done and refused stand until the next accepted command
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         busy_ff       <= 1'b0;
         done_ff       <= 1'b0;
         refused_ff    <= 1'b0;
         swapSet_ok_ff <= 1'b0;
      end else if (launchCmd) begin
         busy_ff       <= 1'b1;
         done_ff       <= 1'b0;
         refused_ff    <= 1'b0;
         swapSet_ok_ff <= 1'b0;
      end else if (busy_ff && nxt_state == ST_IDLE) begin
         busy_ff    <= 1'b0;
         done_ff    <= (state_ff == ST_POLL);
         refused_ff <= (state_ff == ST_CHECK);
      end else if (state_ff == ST_WRSWAP && xferDone) begin
         swapSet_ok_ff <= 1'b1;
      end
   end

endmodule : eafsl_ctrl

//--- verilog/eafsl_pkg.sv
// Constants and types shared by the extra-area flag launch controller.
// Assumes a 32-bit APB slave side for software and an APB master side
// reaching the flash sequencer register window of the device.
package eafsl_pkg;

   // ----------------------------------------------------------------
   // Software-facing register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] SW_CMD_OFS    = 8'h00;
   localparam logic [7:0] SW_ARGA_OFS   = 8'h04;
   localparam logic [7:0] SW_ARGB_OFS   = 8'h08;
   localparam logic [7:0] SW_STATUS_OFS = 8'h0c;
   localparam logic [7:0] SW_SECRD_OFS  = 8'h10;

   // Command codes in the command register
   localparam logic [1:0] CMD_NONE      = 2'h0;
   localparam logic [1:0] CMD_BOOT_PROT = 2'h1;
   localparam logic [1:0] CMD_BOOT_SWAP = 2'h2;
   localparam logic [1:0] CMD_SHIELD    = 2'h3;

   // Status register bit positions
   localparam int ST_BUSY_BIT    = 0;
   localparam int ST_DONE_BIT    = 1;
   localparam int ST_REFUSED_BIT = 2;
   localparam int ST_SWAPSET_BIT = 3;

   // ----------------------------------------------------------------
   // Device register map (byte addresses on the master side)
   // ----------------------------------------------------------------
   localparam logic [15:0] DEV_AREA_SEL_ADDR  = 16'h0000;
   localparam logic [15:0] DEV_SEC_FLAG_ADDR  = 16'h0004;
   localparam logic [15:0] DEV_WDATA_LO_ADDR  = 16'h0008;
   localparam logic [15:0] DEV_WDATA_HI_ADDR  = 16'h000c;
   localparam logic [15:0] DEV_SEQ_START_ADDR = 16'h0010;
   localparam logic [15:0] DEV_SWAP_SET_ADDR  = 16'h0014;
   localparam logic [15:0] DEV_SEQ_STAT_ADDR  = 16'h0018;

   // Device register values and field positions
   localparam logic [7:0]  AREA_SEL_EXTRA    = 8'h01;
   localparam logic [7:0]  START_SEC_FLAG    = 8'h81;
   localparam logic [7:0]  START_SHIELD      = 8'h82;
   localparam logic [15:0] MASK_ALL_ONES     = 16'hffff;
   localparam logic [15:0] MASK_BOOT_CLUS1   = 16'hfeff;
   localparam int          BOOT_FLAG_BIT     = 8;
   localparam int          BOOT_PROT_BIT     = 9;
   localparam int          TMP_SWAP_MODE_BIT = 7;
   localparam int          TMP_BOOT_SEL_BIT  = 6;
   localparam int          BLOCK_NUM_W       = 10;
   localparam logic [7:0]  CLUSTER1_CODE     = 8'h00;

   // Device sequencer status bits
   localparam int DST_CODE_MODE_BIT  = 0;
   localparam int DST_FLASH_BUSY_BIT = 1;
   localparam int DST_EXTRA_BUSY_BIT = 2;

   // One master-side transfer
   typedef struct packed {
      logic [15:0] addr;
      logic        write;
      logic [31:0] wdata;
   } eafsl_xfer_t;

endpackage : eafsl_pkg

//--- tb/eafsl_ctrl_asserts.sv
// Port checker for the extra-area flag launch controller.
// Assumes a bind onto eafsl_ctrl; one clock domain, async reset.
`timescale 1ns/100ps
module eafsl_ctrl_asserts (
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        mPsel,
   input wire logic        mPenable,
   input wire logic        mPwrite,
   input wire logic [15:0] mPaddr,
   input wire logic [31:0] mPwdata,
   input wire logic [31:0] mPrdata,
   input wire logic        mPready
);
   // ---------------------------------------------------------------
   // Helper state
   // ---------------------------------------------------------------
   logic        done;
   logic        areaSeen_ff;
   logic [31:0] hiVal_ff;
   logic        pollDue_ff;
   assign done = mPsel && mPenable && mPready;
   // Area select seen, last high data, poll owed after a launch
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         areaSeen_ff <= 1'b0;
         hiVal_ff    <= 32'h0;
         pollDue_ff  <= 1'b0;
      end else if (done) begin
         pollDue_ff  <= mPwrite && (mPaddr == eafsl_pkg::DEV_SEQ_START_ADDR);
         // Armed by the area select, spent by the start write
         areaSeen_ff <= mPwrite ? (mPaddr == eafsl_pkg::DEV_AREA_SEL_ADDR)
            || (areaSeen_ff && mPaddr != eafsl_pkg::DEV_SEQ_START_ADDR) : areaSeen_ff;
         hiVal_ff    <= (mPwrite && mPaddr == eafsl_pkg::DEV_WDATA_HI_ADDR) ? mPwdata : hiVal_ff;
      end
   end
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   AST_AREA_VAL: assert property (mPsel && mPwrite && mPaddr == eafsl_pkg::DEV_AREA_SEL_ADDR
      |-> mPwdata == 32'h1) else $error("area select value wrong");
   AST_AREA_FIRST: assert property (done && mPwrite && mPaddr == eafsl_pkg::DEV_SEQ_START_ADDR
      |-> areaSeen_ff) else $error("launch without area select just before");
   AST_START_CODE: assert property (mPsel && mPwrite && mPaddr == eafsl_pkg::DEV_SEQ_START_ADDR
      |-> mPwdata == 32'h81 || mPwdata == 32'h82) else $error("start code wrong");
   AST_HI_MASK: assert property (done && mPwrite && mPaddr == eafsl_pkg::DEV_SEQ_START_ADDR
      && mPwdata == 32'h81 |-> hiVal_ff == 32'hffff) else $error("high data not all ones");
   AST_POLL_NEXT: assert property (pollDue_ff && mPsel
      |-> !mPwrite && mPaddr == eafsl_pkg::DEV_SEQ_STAT_ADDR) else $error("no poll after launch");
   AST_SWAP_SET: assert property (mPsel && mPwrite && mPaddr == eafsl_pkg::DEV_SWAP_SET_ADDR
      |-> mPwdata[7]) else $error("swap write lacks mode bit");
   AST_UPPER_ZERO: assert property (mPsel && mPwrite && mPaddr[15:3] == 13'h1
      |-> mPwdata[31:16] == 16'h0) else $error("data upper half not zero");
   AST_HOLD: assert property (mPsel && mPenable && !mPready
      |=> mPenable && $stable(mPaddr) && $stable(mPwdata) && $stable(mPwrite))
      else $error("request changed while waiting");
   AST_SETUP: assert property (mPsel && !mPenable |=> mPsel && mPenable)
      else $error("setup not followed by access");
   AST_GAP: assert property (done |=> !mPsel && !mPenable) else $error("no idle after transfer");
   AST_SLVERR: assert property (psel && penable && paddr > 8'h10 |-> pslverr && pready)
      else $error("unmapped access not flagged");
endmodule : eafsl_ctrl_asserts

//--- tb/eafsl_dev_model.sv
// Behavioural register window of the flash sequencer in the device.
// Assumes an APB master on the far side; flag storage survives reset.
`timescale 1ns/100ps
module eafsl_dev_model #(
   parameter logic [15:0] SEC_INIT = 16'h0b5a,
   parameter int          BUSY_CYC = 6
) (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [15:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   input  wire logic        codeMode,
   input  wire logic        flashBusy,
   input  wire logic [1:0]  waitCyc,
   output logic             bootCl
);
   logic [15:0] secFlag_ff = SEC_INIT;
   logic [7:0]  swap_ff = 8'h00;
   logic [15:0] wLo_ff;
   logic [2:0]  mode_ff;
   logic [7:0]  busy_ff;
   logic [1:0]  wait_ff;
   logic [31:0] rd;
   logic [31:0] lastRd_ff;
   logic [19:0] clus1Base;
   logic        wr;
   assign pready = psel && penable && (wait_ff == waitCyc);
   assign wr     = pready && pwrite;
   assign clus1Base = bootCl ? 20'h00000 : 20'h04000;
   // Read mux; a released bus shows the inverse of the last data
   always_comb begin
      case (paddr)
         eafsl_pkg::DEV_SEC_FLAG_ADDR: rd = {16'h0, secFlag_ff};
         eafsl_pkg::DEV_SWAP_SET_ADDR: rd = {24'h0, swap_ff};
         eafsl_pkg::DEV_SEQ_STAT_ADDR: rd = {29'h0, busy_ff != 8'h0, flashBusy, codeMode};
         default:                      rd = 32'h0;
      endcase
      prdata = pready ? rd : ~lastRd_ff;
   end
   // Wait states and sequencer run time
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wait_ff   <= 2'h0;
         busy_ff   <= 8'h0;
         lastRd_ff <= 32'h0;
      end else begin
         wait_ff   <= (psel && penable && !pready) ? wait_ff + 2'h1 : 2'h0;
         lastRd_ff <= pready ? rd : lastRd_ff;
         if (wr && paddr == eafsl_pkg::DEV_SEQ_START_ADDR && pwdata[7]) begin
            busy_ff <= 8'(BUSY_CYC);
         end else if (busy_ff != 8'h0) begin
            busy_ff <= busy_ff - 8'h1;
         end
      end
   end
   // Flag storage is kept across reset, like the real extra area
   always @(posedge clock) begin
      if (wr && paddr == eafsl_pkg::DEV_WDATA_LO_ADDR) wLo_ff <= pwdata[15:0];
      if (wr && paddr == eafsl_pkg::DEV_SWAP_SET_ADDR) swap_ff <= pwdata[7:0];
      if (wr && paddr == eafsl_pkg::DEV_SEQ_START_ADDR) mode_ff <= pwdata[2:0];
      if (busy_ff == 8'h1 && mode_ff == 3'h1) secFlag_ff <= secFlag_ff & wLo_ff;
   end
   // Boot cluster only follows the flags while reset is applied
   always_latch begin
      if (!rst_n) bootCl <= swap_ff[7] ? swap_ff[6] : !secFlag_ff[8];
   end
endmodule : eafsl_dev_model

//--- tb/eafsl_ctrl_tb_top.sv
// Self-checking bench for the extra-area flag launch controller.
// Assumes the device model and the port checker are compiled first.
`timescale 1ns/100ps
module eafsl_ctrl_tb_top;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, mPwdata, mPrdata;
   logic [15:0] mPaddr;
   logic        pready, pslverr, mPsel, mPenable, mPwrite, mPready, bootCl, lastErr;
   logic        codeMode = 1'b1;
   logic        flashBusy = 1'b0;
   logic [1:0]  waitCyc = 2'h0;
   logic [47:0] wq[$];
   int          fails = 0;
   int          comparisons = 0;
   eafsl_ctrl u_dut (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .mPsel, .mPenable, .mPwrite, .mPaddr, .mPwdata, .mPrdata, .mPready);
   eafsl_dev_model u_dev (.clock, .rst_n, .psel(mPsel), .penable(mPenable), .pwrite(mPwrite),
      .paddr(mPaddr), .pwdata(mPwdata), .prdata(mPrdata), .pready(mPready), .codeMode,
      .flashBusy, .waitCyc, .bootCl);
   always #5 clock = ~clock;
   // Log every completed device write
   always @(posedge clock) begin
      if (mPsel && mPenable && mPready === 1'b1 && mPwrite) wq.push_back({mPaddr, mPwdata});
   end
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic give_verdict;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // One APB transfer; held until pready is seen at an edge
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
      int n;
      psel   <= 1'b1;
      paddr  <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         fails++;
         give_verdict();
      end
      r = prdata;
      lastErr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask : apb
   // Arguments, command, then poll until busy clears
   task automatic run(input logic [1:0] cmd, input logic [31:0] a, input logic [31:0] b,
                      output logic [31:0] st);
      int n;
      logic [31:0] r;
      apb(eafsl_pkg::SW_ARGA_OFS, 1'b1, a, r);
      apb(eafsl_pkg::SW_ARGB_OFS, 1'b1, b, r);
      apb(eafsl_pkg::SW_CMD_OFS, 1'b1, {30'h0, cmd}, r);
      n = 0;
      do begin
         apb(eafsl_pkg::SW_STATUS_OFS, 1'b0, 32'h0, st);
         n++;
      end while (st[0] !== 1'b0 && n < 200);
      if (n >= 200) begin
         fails++;
         give_verdict();
      end
   endtask : run
   task automatic expw(input logic [15:0] a, input logic [31:0] d);
      logic [47:0] got;
      got = (wq.size() > 0) ? wq.pop_front() : 48'h0;
      chk("device write address", {16'h0, a}, {16'h0, got[47:32]});
      chk("device write data", d, got[31:0]);
   endtask : expw
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      logic [31:0] st;
      logic [31:0] r;
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      apb(8'h20, 1'b0, 32'h0, r);
      chk("unmapped error", 32'h1, {31'h0, lastErr});
      chk("boot cluster at start", 32'h0, {31'h0, bootCl});
      // Protect launch against a slow device
      waitCyc <= 2'h2;
      run(eafsl_pkg::CMD_BOOT_PROT, 32'h0, 32'h0, st);
      chk("protect status", 32'h2, st & 32'h7);
      expw(eafsl_pkg::DEV_AREA_SEL_ADDR, 32'h1);
      expw(eafsl_pkg::DEV_WDATA_LO_ADDR, 32'h095a);
      expw(eafsl_pkg::DEV_WDATA_HI_ADDR, 32'hffff);
      expw(eafsl_pkg::DEV_SEQ_START_ADDR, 32'h81);
      apb(eafsl_pkg::SW_SECRD_OFS, 1'b0, 32'h0, r);
      chk("security flags read", 32'h0b5a, r);
      // Swap to cluster 1, then an odd code that means cluster 0
      waitCyc <= 2'h0;
      run(eafsl_pkg::CMD_BOOT_SWAP, 32'h0, 32'h0, st);
      chk("swap status", 32'ha, st & 32'hf);
      expw(eafsl_pkg::DEV_SWAP_SET_ADDR, 32'h80);
      expw(eafsl_pkg::DEV_AREA_SEL_ADDR, 32'h1);
      expw(eafsl_pkg::DEV_WDATA_LO_ADDR, 32'hfeff);
      expw(eafsl_pkg::DEV_WDATA_HI_ADDR, 32'hffff);
      expw(eafsl_pkg::DEV_SEQ_START_ADDR, 32'h81);
      chk("boot cluster before reset", 32'h0, {31'h0, bootCl});
      run(eafsl_pkg::CMD_BOOT_SWAP, 32'h5, 32'h0, st);
      expw(eafsl_pkg::DEV_AREA_SEL_ADDR, 32'h1);
      expw(eafsl_pkg::DEV_WDATA_LO_ADDR, 32'hffff);
      expw(eafsl_pkg::DEV_WDATA_HI_ADDR, 32'hffff);
      expw(eafsl_pkg::DEV_SEQ_START_ADDR, 32'h81);
      // Shield window with junk in the upper bits
      run(eafsl_pkg::CMD_SHIELD, 32'hfc0c, 32'hfc10, st);
      expw(eafsl_pkg::DEV_AREA_SEL_ADDR, 32'h1);
      expw(eafsl_pkg::DEV_WDATA_LO_ADDR, 32'h000c);
      expw(eafsl_pkg::DEV_WDATA_HI_ADDR, 32'h0010);
      expw(eafsl_pkg::DEV_SEQ_START_ADDR, 32'h82);
      // Wrong mode, then a busy flash sequencer: nothing may be written
      for (int i = 0; i < 2; i++) begin
         codeMode  <= (i == 1);
         flashBusy <= (i == 1);
         run(eafsl_pkg::CMD_SHIELD, 32'h1, 32'h2, st);
         chk("refused flag", 32'h4, st & 32'h4);
      end
      chk("stray device writes", 32'h0, 32'(wq.size()));
      // Second reset applies the temporary select
      rst_n <= 1'b0;
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      chk("boot cluster after reset", 32'h0, {31'h0, bootCl});
      chk("cluster 1 base", 32'h4000, {12'h0, u_dev.clus1Base});
      give_verdict();
   end
endmodule : eafsl_ctrl_tb_top
bind eafsl_ctrl eafsl_ctrl_asserts u_chk (.clock, .rst_n, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .mPsel, .mPenable, .mPwrite, .mPaddr, .mPwdata,
   .mPrdata, .mPready);
